// ---- hdl/chg_defs.svh ----
`ifndef CHG_DEFS_SVH
`define CHG_DEFS_SVH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define CHG_SLAVE_ADDR 7'h6A
`define CHG_REG_STATUS 8'h00
`define CHG_REG_FAULT 8'h01
`define CHG_UNMAPPED_DATA 8'hFF
`define CHG_STATUS_RESET 8'h01
`define CHG_MASK_RESET 4'h0

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CHG_ST_SHIP_BIT 5
`define CHG_ST_RESETF_BIT 4
`define CHG_FL_UV_BIT 6
`define CHG_FL_OCP_BIT 4

// ---------------------------------------------------------------
// timing: hang timeout in microseconds at a 200 MHz clock
// ---------------------------------------------------------------
`define CHG_CLK_MHZ 200
`define CHG_HANG_US 50000
`define CHG_HANG_CYCLES (`CHG_HANG_US * `CHG_CLK_MHZ)
`define CHG_ALERT_CYCLES 8'd200

`endif

// ---- hdl/chg_pkg.sv ----
package chg_pkg;

    typedef enum logic [2:0] {
        CHG_IDLE,
        CHG_ADDR,
        CHG_REG,
        CHG_WDATA,
        CHG_RDATA,
        CHG_IGNORE
    } chg_phase_t;

    typedef enum logic [1:0] {
        CHG_READY = 2'b00,
        CHG_CHARGING = 2'b01,
        CHG_DONE = 2'b10,
        CHG_FAULT = 2'b11
    } chg_state_t;

endpackage

// ---- hdl/chg_pin_sync.sv ----
`timescale 1ns/100ps
`include "chg_defs.svh"

// two-stage synchroniser for a group of pins from outside clk_sys
module chg_pin_sync
import chg_pkg::*;
#(
    parameter int WIDTH = 2
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pin_in,
    input wire logic [WIDTH-1:0] pin_reset_val,
    output logic [WIDTH-1:0] pin_sync
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } chg_sync_state_t;

    chg_sync_state_t st;
    chg_sync_state_t next_st;

    // first stage feeds only the second stage; flops hold the
    // difference from the reset level, so reset loads only zeros
    always_comb
    begin
        next_st = st;
        next_st.meta = pin_in ^ pin_reset_val;
        next_st.sync = st.meta;
    end

    // per-pin reset level is tied at the instance, so no false edges
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign pin_sync = st.sync ^ pin_reset_val;

endmodule

// ---- hdl/chg_i2c_regs.sv ----
`timescale 1ns/100ps
`include "chg_defs.svh"

// Notes on behaviour
// - slave only, 100 and 400 kbps alike
// - seven-bit address 6A only
// - SDA stuck low resets the serial engine
// - hang timer restarts on start, stops on stop
// - SDA falling with SCL high is start
// - acknowledge only a matching address
// - direction bit 0 write, 1 read
// - eight bits then one acknowledge bit
// - stop releases bus, await new start
// - unmapped register reads return FF
// - bits 7:6 show live charge state
// - bit 5 write-only ship mode request
// - push-button reset flag clears on read
// - timer fault kept until chip-disable toggles
// - bits 2..0 show dpm, disable pin, switcher
// - overvoltage flag stays while condition persists
// - undervoltage flag reported once, clear on read
// - battery lockout flag stays while condition persists
// - overcurrent flag clears after a read
// - fault bits 3:0 are mask bits
// - overvoltage forces fault state, power bad, alert unless masked
module chg_i2c_regs
import chg_pkg::*;
#(
    parameter int unsigned HANG_CYCLES = `CHG_HANG_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic [1:0] charge_state,
    input wire logic reset_condition,
    input wire logic timer_fault,
    input wire logic input_dpm_active,
    input wire logic chip_disable_pin,
    input wire logic system_switcher_on,
    input wire logic input_overvoltage,
    input wire logic input_undervoltage,
    input wire logic battery_lockout,
    input wire logic battery_overcurrent,
    output logic ship_mode_request,
    output logic host_alert,
    output logic power_good_output
);

    // ---------------------------------------------------------------
    // reset release and pin synchronisers
    // ---------------------------------------------------------------
    logic [1:0] rst_sync;
    logic rst_int_n;

    // async assert, release through two flops
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_sync <= 2'b00;
        end
        else
        begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_int_n = rst_sync[1];

    localparam int NPIN = 11;
    logic [NPIN-1:0] pins;
    logic [NPIN-1:0] pins_s;
    assign pins = {scl_in, sda_in, charge_state, reset_condition,
                   timer_fault, input_dpm_active, chip_disable_pin,
                   system_switcher_on, input_overvoltage,
                   input_undervoltage};
    logic [1:0] misc_s;

    chg_pin_sync #(.WIDTH(NPIN)) u_sync_a
    (
        .clk_sys(clk_sys),
        .rst_n(rst_int_n),
        .pin_in(pins),
        .pin_reset_val(11'h600), // bus lines idle high, inputs low
        .pin_sync(pins_s)
    );
    chg_pin_sync #(.WIDTH(2)) u_sync_b
    (
        .clk_sys(clk_sys),
        .rst_n(rst_int_n),
        .pin_in({battery_lockout, battery_overcurrent}),
        .pin_reset_val('0),
        .pin_sync(misc_s)
    );

    logic scl_s, sda_s, rstc_s, tmr_s, dpm_s, cd_s, sw_s, ov_s, uv_s;
    logic lock_s, ocp_s;
    logic [1:0] cst_s;
    assign {scl_s, sda_s, cst_s, rstc_s, tmr_s, dpm_s, cd_s, sw_s,
            ov_s, uv_s} = pins_s;
    assign {lock_s, ocp_s} = misc_s;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic scl_d;
        logic sda_d;
        logic cd_d;
        logic ov_d;
        logic uv_d;
        logic lock_d;
        logic ocp_d;
        chg_phase_t phase;
        logic [3:0] bitn;
        logic [7:0] shreg;
        logic rw;
        logic ack_phase;
        logic drive_low;
        logic [7:0] reg_ptr;
        logic [31:0] hang_cnt;
        logic hang_run;
        logic ship;
        logic resetf;
        logic timerf;
        logic uvf;
        logic ocpf;
        logic [3:0] mask;
        logic [7:0] alert_cnt;
    } chg_state_all_t;

    chg_state_all_t st;
    chg_state_all_t next_st;

    // read data for a register pointer; unmapped gives all ones
    function automatic logic [7:0] read_byte(input logic [7:0] ptr,
                                             input chg_state_all_t s,
                                             input logic [1:0] live,
                                             input logic [5:0] lv);
        logic [7:0] v;
        v = `CHG_UNMAPPED_DATA;
        if (ptr == `CHG_REG_STATUS)
            v = {live, 1'b0, s.resetf, s.timerf, lv[2:0]};
        else if (ptr == `CHG_REG_FAULT)
            v = {lv[5], s.uvf, lv[4], s.ocpf, s.mask};
        return v;
    endfunction

    logic [1:0] live_state;
    // overvoltage overrides the charge state field
    assign live_state = ov_s ? CHG_FAULT : cst_s;

    logic start_c, stop_c, scl_rise, scl_fall;
    assign start_c = st.scl_d && scl_s && st.sda_d && !sda_s;
    assign stop_c = st.scl_d && scl_s && !st.sda_d && sda_s;
    assign scl_rise = !st.scl_d && scl_s;
    assign scl_fall = st.scl_d && !scl_s;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb
    begin
        logic [7:0] rb;
        logic rd_done;
        logic [7:0] rd_ptr;
        rb = 8'h00;
        rd_done = 1'b0;
        rd_ptr = st.reg_ptr;
        next_st = st;
        next_st.scl_d = scl_s;
        next_st.sda_d = sda_s;
        next_st.cd_d = cd_s;
        next_st.ov_d = ov_s;
        next_st.uv_d = uv_s;
        next_st.lock_d = lock_s;
        next_st.ocp_d = ocp_s;

        // bus hang timer counts while a frame runs and sda is low
        if (st.hang_run && !sda_s)
            next_st.hang_cnt = st.hang_cnt + 32'd1;
        else
            next_st.hang_cnt = 32'd0;

        case (st.phase)
            CHG_IDLE, CHG_IGNORE:
            begin
                next_st.drive_low = 1'b0;
            end
            default:
            begin
                if (scl_rise && !st.ack_phase)
                begin
                    next_st.shreg = {st.shreg[6:0], sda_s};
                    next_st.bitn = st.bitn + 4'd1;
                end
                else if (scl_rise && st.ack_phase && st.phase == CHG_RDATA)
                begin
                    // master nack ends the read burst
                    if (sda_s)
                        next_st.phase = CHG_IGNORE;
                end
                else if (scl_fall && st.ack_phase)
                begin
                    // acknowledge cycle over, release and prepare next byte
                    next_st.ack_phase = 1'b0;
                    next_st.drive_low = 1'b0;
                    next_st.bitn = 4'd0;
                    if (st.phase == CHG_RDATA)
                    begin
                        rb = read_byte(st.reg_ptr, st, live_state,
                            {ov_s, lock_s, 1'b0, dpm_s, cd_s, sw_s});
                        next_st.shreg = rb;
                        next_st.drive_low = !rb[7];
                        rd_done = 1'b1;
                        next_st.reg_ptr = st.reg_ptr + 8'd1;
                    end
                end
                else if (scl_fall && st.bitn == 4'd8)
                begin
                    // eighth clock falls: pick acknowledge per phase
                    next_st.ack_phase = 1'b1;
                    case (st.phase)
                        CHG_ADDR:
                        begin
                            if (st.shreg[7:1] == `CHG_SLAVE_ADDR)
                            begin
                                next_st.drive_low = 1'b1;
                                next_st.rw = st.shreg[0];
                                next_st.phase = st.shreg[0] ? CHG_RDATA
                                                            : CHG_REG;
                            end
                            else
                            begin
                                next_st.phase = CHG_IGNORE;
                            end
                        end
                        CHG_REG:
                        begin
                            next_st.reg_ptr = st.shreg;
                            next_st.drive_low = 1'b1;
                            next_st.phase = CHG_WDATA;
                        end
                        CHG_WDATA:
                        begin
                            next_st.drive_low = 1'b1;
                            if (st.reg_ptr == `CHG_REG_STATUS)
                                next_st.ship = st.shreg[`CHG_ST_SHIP_BIT];
                            else if (st.reg_ptr == `CHG_REG_FAULT)
                                next_st.mask = st.shreg[3:0];
                            next_st.reg_ptr = st.reg_ptr + 8'd1;
                        end
                        default:
                        begin
                            // read byte sent, master acknowledges
                            next_st.drive_low = 1'b0;
                        end
                    endcase
                end
                else if (scl_fall && st.phase == CHG_RDATA)
                begin
                    next_st.drive_low = !st.shreg[7]; // shifts on each rise
                end
            end
        endcase

        // first read byte loads when the address acknowledge ends
        if (rd_done)
            rd_ptr = st.reg_ptr;

        // clear-on-read flags clear when their byte is loaded
        if (rd_done && rd_ptr == `CHG_REG_STATUS)
            next_st.resetf = 1'b0;
        if (rd_done && rd_ptr == `CHG_REG_FAULT)
        begin
            next_st.uvf = 1'b0;
            next_st.ocpf = 1'b0;
        end

        // hardware set wins over a read clear
        if (rstc_s)
            next_st.resetf = 1'b1;
        if (uv_s && !st.uv_d)
            next_st.uvf = 1'b1;
        if (ocp_s && !st.ocp_d)
            next_st.ocpf = 1'b1;
        if (tmr_s)
            next_st.timerf = 1'b1;
        else if (cd_s != st.cd_d)
            next_st.timerf = 1'b0;

        // alert pulse on any unmasked rising fault
        if ((ov_s && !st.ov_d && !st.mask[3]) ||
            (uv_s && !st.uv_d && !st.mask[2]) ||
            (lock_s && !st.lock_d && !st.mask[1]) ||
            (ocp_s && !st.ocp_d && !st.mask[0]))
            next_st.alert_cnt = `CHG_ALERT_CYCLES;
        else if (st.alert_cnt != 8'd0)
            next_st.alert_cnt = st.alert_cnt - 8'd1;

        // frame control has the last word
        if (start_c)
        begin
            next_st.phase = CHG_ADDR;
            next_st.bitn = 4'd0;
            next_st.ack_phase = 1'b0;
            next_st.drive_low = 1'b0;
            next_st.hang_run = 1'b1;
            next_st.hang_cnt = 32'd0;
        end
        else if (stop_c)
        begin
            next_st.phase = CHG_IDLE;
            next_st.drive_low = 1'b0;
            next_st.hang_run = 1'b0;
        end
        else if (st.hang_cnt >= HANG_CYCLES)
        begin
            next_st.phase = CHG_IDLE;
            next_st.drive_low = 1'b0;
            next_st.hang_run = 1'b0;
            next_st.ack_phase = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_int_n)
    begin
        if (!rst_int_n)
        begin
            st <= '0;
            st.scl_d <= 1'b1;
            st.sda_d <= 1'b1;
            st.phase <= CHG_IDLE;
            st.mask <= `CHG_MASK_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    // open-drain data: enable low means pulling low
    assign sda_out = 1'b0;
    assign sda_oe_n = !st.drive_low;
    assign ship_mode_request = st.ship;
    assign host_alert = st.alert_cnt != 8'd0;
    assign power_good_output = !st.ov_d && !st.uv_d;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    property p_stop_idle;
        @(posedge clk_sys) disable iff (!rst_int_n)
        stop_c |=> st.phase == CHG_IDLE && !st.drive_low;
    endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("stop did not release the bus");

    property p_start_addr;
        @(posedge clk_sys) disable iff (!rst_int_n)
        start_c |=> st.phase == CHG_ADDR && st.bitn == 4'd0;
    endproperty
    a_start_addr: assert property (p_start_addr)
        else $error("start not taken");

    property p_hang;
        @(posedge clk_sys) disable iff (!rst_int_n)
        (st.hang_cnt >= HANG_CYCLES && !start_c && !stop_c)
            |=> st.phase == CHG_IDLE;
    endproperty
    a_hang: assert property (p_hang)
        else $error("hang timeout did not reset engine");

    property p_nack_foreign;
        @(posedge clk_sys) disable iff (!rst_int_n)
        (st.phase == CHG_ADDR && scl_fall && st.bitn == 4'd8 &&
         st.shreg[7:1] != `CHG_SLAVE_ADDR && !start_c && !stop_c)
            |=> !st.drive_low;
    endproperty
    a_nack_foreign: assert property (p_nack_foreign)
        else $error("acked a foreign address");

    property p_ship_write;
        @(posedge clk_sys) disable iff (!rst_int_n)
        (st.phase == CHG_WDATA && scl_fall && !st.ack_phase &&
         st.bitn == 4'd8 && st.reg_ptr == `CHG_REG_STATUS)
            |=> st.ship == $past(st.shreg[`CHG_ST_SHIP_BIT]);
    endproperty
    a_ship_write: assert property (p_ship_write)
        else $error("ship request not taken from write");

    property p_ov_fault;
        @(posedge clk_sys) disable iff (!rst_int_n)
        (ov_s && st.ov_d) |-> live_state == CHG_FAULT && !power_good_output;
    endproperty
    a_ov_fault: assert property (p_ov_fault)
        else $error("overvoltage not forcing fault");

    property p_mask_alert;
        @(posedge clk_sys) disable iff (!rst_int_n)
        (!host_alert && ({ov_s && !st.ov_d, uv_s && !st.uv_d,
                          lock_s && !st.lock_d, ocp_s && !st.ocp_d}
                         & ~st.mask) == 4'h0)
            |=> !host_alert;
    endproperty
    a_mask_alert: assert property (p_mask_alert)
        else $error("masked fault raised alert");

    property p_uv_set;
        @(posedge clk_sys) disable iff (!rst_int_n)
        (uv_s && !st.uv_d) |=> st.uvf;
    endproperty
    a_uv_set: assert property (p_uv_set)
        else $error("undervoltage flag not set");

    property p_timer_hold;
        @(posedge clk_sys) disable iff (!rst_int_n)
        (st.timerf && cd_s == st.cd_d) |=> st.timerf;
    endproperty
    a_timer_hold: assert property (p_timer_hold)
        else $error("timer fault cleared without pin toggle");

endmodule

// ---- test/chg_i2c_master.sv ----
`timescale 1ns/100ps

// ---------------------------------------------------------------
// bus master model
// ---------------------------------------------------------------
// drives scl push-pull, pulls sda low or lets the pull-up win
module chg_i2c_master
(
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    localparam real Q = 16.0;
    logic [8:0] got;
    event got_ev;

    // idle bus: both lines high
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
        got = 9'h000;
    end

    // one 64 ns bit; data moves a quarter after scl falls
    task automatic bit_io(input logic b, output logic r);
        #Q sda_low = !b;
        #Q scl = 1'b1;
        #Q r = sda;
        #Q scl = 1'b0;
    endtask

    // also serves as repeated start: release waits for the ack to end
    task automatic start();
        #Q sda_low = 1'b0;
        #Q scl = 1'b1;
        #Q sda_low = 1'b1;
        #Q scl = 1'b0;
    endtask

    // master closes every transfer, even abandoned ones
    task automatic stop();
        #Q sda_low = 1'b1;
        #Q scl = 1'b1;
        #Q sda_low = 1'b0;
        #Q;
    endtask

    // a stuck-low data line, kept off the system clock grid
    task automatic hold(input int n);
        sda_low = 1'b1;
        repeat (n) #5;
    endtask

    // eight bits msb first, then the receiver's ack bit
    task automatic xfer(input logic [7:0] b, input logic rd,
                        input logic mack);
        logic [7:0] d;
        logic r;
        logic a;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(rd ? 1'b1 : b[i], r);
            d[i] = r;
        end
        bit_io(rd ? mack : 1'b1, a);
        got = {a, d};
        ->got_ev;
    endtask
endmodule

// ---- test/charger_i2c_status_fault_regs_bench.sv ----
`timescale 1ns/100ps

module charger_i2c_status_fault_regs_bench
import chg_pkg::*;
;
    logic clk_sys;
    logic rst_n;
    wire scl;
    wire sda;
    logic m_low;
    logic sda_out;
    logic sda_oe_n;
    logic [1:0] cs;
    logic rc, tf, dpm, cd, system_rail, ov, uv, bl, oc;
    logic ship, alert, pg;
    int bad_count;
    int compares;
    int seed;
    int n;
    logic [8:0] exp_q[$];
    logic [7:0] tbl [3];

    // open drain with pull-up: low if anyone pulls
    assign sda = !m_low && (sda_oe_n || sda_out);

    chg_i2c_master m (.sda(sda), .scl(scl), .sda_low(m_low));

    chg_i2c_regs #(.HANG_CYCLES(2000)) uut (
        .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .charge_state(cs),
        .reset_condition(rc), .timer_fault(tf), .input_dpm_active(dpm),
        .chip_disable_pin(cd), .system_switcher_on(system_rail),
        .input_overvoltage(ov), .input_undervoltage(uv),
        .battery_lockout(bl), .battery_overcurrent(oc),
        .ship_mode_request(ship), .host_alert(alert),
        .power_good_output(pg));

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = !clk_sys;
    end

    task automatic check(input logic [8:0] seen, input logic [8:0] want);
        compares++;
        if (seen !== want)
        begin
            bad_count++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic results();
        if (bad_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // oldest note against each byte the master finishes
    initial
    forever
    begin
        @(m.got_ev);
        check(m.got, exp_q.pop_front());
    end

    // expected status byte from the live pins and two sticky bits
    function automatic logic [7:0] st(input logic [1:0] c,
                                      input logic [1:0] f);
        return {c, 1'b0, f, dpm, cd, system_rail};
    endfunction

    task automatic wr_reg(input logic [7:0] r, input logic [7:0] d);
        @(negedge clk_sys);
        #0.3;
        exp_q.push_back({1'b0, 8'hD4});
        exp_q.push_back({1'b0, r});
        exp_q.push_back({1'b0, d});
        m.start();
        m.xfer(8'hD4, 1'b0, 1'b0);
        m.xfer(r, 1'b0, 1'b0);
        m.xfer(d, 1'b0, 1'b0);
        m.stop();
    endtask

    // pointer write, repeated start, one byte then nack
    task automatic rd_reg(input logic [7:0] r, input logic [7:0] e);
        @(negedge clk_sys);
        #0.3;
        exp_q.push_back({1'b0, 8'hD4});
        exp_q.push_back({1'b0, r});
        exp_q.push_back({1'b0, 8'hD5});
        exp_q.push_back({1'b1, e});
        m.start();
        m.xfer(8'hD4, 1'b0, 1'b0);
        m.xfer(r, 1'b0, 1'b0);
        m.start();
        m.xfer(8'hD5, 1'b0, 1'b0);
        m.xfer(8'h00, 1'b1, 1'b1);
        m.stop();
    endtask

    // alert high length, after waiting up to 100 cycles for it
    task automatic alert_len(output int k);
        k = 0;
        repeat (100) if (alert !== 1'b1) @(negedge clk_sys);
        while (alert === 1'b1 && k < 400)
        begin
            @(negedge clk_sys);
            k++;
        end
    endtask

    // pin changes at the falling edge, given time to synchronise
    task automatic pin_wait();
        repeat (20) @(negedge clk_sys);
    endtask

    // watchdog: the whole run needs well under 200 us
    initial
    begin
        #400_000;
        bad_count++;
        results();
    end

    initial
    begin
        {rc, tf, dpm, cd, ov, uv, bl, oc} = 8'h00;
        cs = 2'b00;
        system_rail = 1'b1;
        rst_n = 1'b0;
        bad_count = 0;
        compares = 0;
        seed = 32'h0000_9661;
        repeat (4) @(negedge clk_sys);
        rst_n = 1'b1;
        pin_wait();
        check({8'h00, ship}, 9'h000);
        check({8'h00, pg}, 9'h001);
        rd_reg(8'h00, 8'h01);
        rd_reg(8'h01, 8'h00);
        // every charge state with random pin levels
        for (int i = 0; i < 4; i++)
        begin
            @(negedge clk_sys);
            cs = i[1:0];
            {dpm, system_rail} = 2'($random(seed));
            pin_wait();
            rd_reg(8'h00, st(cs, 2'b00));
        end
        // foreign addresses get no ack and nothing follows
        tbl = '{8'hD6, 8'h54, 8'hD2};
        for (int j = 0; j < 3; j++)
        begin
            @(negedge clk_sys);
            #0.3;
            exp_q.push_back({1'b1, tbl[j]});
            m.start();
            m.xfer(tbl[j], 1'b0, 1'b0);
            m.stop();
        end
        wr_reg(8'h01, 8'hA5);
        rd_reg(8'h01, 8'h05);
        wr_reg(8'h00, 8'h20);
        check({8'h00, ship}, 9'h001);
        rd_reg(8'h00, st(cs, 2'b00));
        wr_reg(8'h00, 8'h00);
        check({8'h00, ship}, 9'h000);
        tbl = '{8'h02, 8'h07, 8'hFF};
        for (int j = 0; j < 3; j++)
            rd_reg(tbl[j], 8'hFF);
        // stuck data line mid-write: later byte must be ignored
        @(negedge clk_sys);
        #0.3;
        exp_q.push_back({1'b0, 8'hD4});
        exp_q.push_back({1'b0, 8'h01});
        exp_q.push_back({1'b1, 8'h0F});
        m.start();
        m.xfer(8'hD4, 1'b0, 1'b0);
        m.xfer(8'h01, 1'b0, 1'b0);
        m.hold(2100);
        m.xfer(8'h0F, 1'b0, 1'b0);
        m.stop();
        rd_reg(8'h01, 8'h05);
        // masked overcurrent: flag recorded, no alert
        @(negedge clk_sys);
        oc = 1'b1;
        alert_len(n);
        check(9'(n), 9'h000);
        oc = 1'b0;
        rd_reg(8'h01, 8'h15);
        rd_reg(8'h01, 8'h05);
        wr_reg(8'h01, 8'h00);
        @(negedge clk_sys);
        uv = 1'b1;
        pin_wait();
        uv = 1'b0;
        pin_wait();
        rd_reg(8'h01, 8'h40);
        rd_reg(8'h01, 8'h00);
        tf = 1'b1;
        pin_wait();
        tf = 1'b0;
        rd_reg(8'h00, st(cs, 2'b01));
        rd_reg(8'h00, st(cs, 2'b01));
        @(negedge clk_sys);
        cd = 1'b1;
        pin_wait();
        rd_reg(8'h00, st(cs, 2'b00));
        rc = 1'b1;
        pin_wait();
        rc = 1'b0;
        rd_reg(8'h00, st(cs, 2'b10));
        rd_reg(8'h00, st(cs, 2'b00));
        // unmasked overvoltage with battery lockout, both persisting
        @(negedge clk_sys);
        ov = 1'b1;
        alert_len(n);
        check(9'(n), 9'd200);
        check({8'h00, pg}, 9'h000);
        bl = 1'b1;
        pin_wait();
        rd_reg(8'h00, st(2'b11, 2'b00));
        rd_reg(8'h01, 8'hA0);
        rd_reg(8'h01, 8'hA0);
        pin_wait();
        check(9'(exp_q.size()), 9'h000);
        results();
    end
endmodule
